// >>> verilog/sacs_consts.vh
// Purpose: Constants for the converter conversion sequencer.
// Assumes: Core clock 125 MHz; converter times counted in half converter cycles.
// Notes: Definitions only.
`ifndef SACS_CONSTS_VH
`define SACS_CONSTS_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define SACS_RES_W 10
`define SACS_PRESC_W 8
`define SACS_HC_W 6

// ----------------------------------------
// Conversion timing, in half converter clock cycles
// ----------------------------------------
`define SACS_HC_SAMPLE_NORM 6'h03
`define SACS_HC_SAMPLE_FIRST 6'h1B
`define SACS_HC_SAMPLE_AUTO 6'h04
`define SACS_HC_END_NORM 6'h1A
`define SACS_HC_END_FIRST 6'h32
`define SACS_HC_END_AUTO 6'h1B

// ----------------------------------------
// Codes
// ----------------------------------------
`define SACS_SAR_MSB 10'h200
`define SACS_CH_TEMP 4'hF
`define SACS_TRIG_DONE_FLAG 3'h0
`define SACS_MODE_NORM 2'h0
`define SACS_MODE_FIRST 2'h1
`define SACS_MODE_AUTO 2'h2

`endif

// >>> verilog/sacs_sequencer.v
// Purpose: Sequencer of a 10-bit successive-approximation converter.
// Assumes: All inputs synchronous to core_clk; register accesses are strobes.
// Notes: Converter clock is a tick pair from the prescaler, not a real clock.
//
// Notes on behaviour
// - Completed conversion yields 10-bit unsigned result
// - Right aligned unless left align selected
// - Low byte read blocks result updates
// - High byte read re-enables result updates
// - Completion event raised even when blocked
// - Start bit stays set until conversion ends
// - Channel change waits for current conversion
// - Selections apply only while converter on
// - Trigger edge resets prescaler, starts conversion
// - Edges during conversion and held levels ignored
// - Trigger flag must be cleared by software
// - Done flag trigger gives back-to-back conversions
// - Start bit works, reads one while converting
// - Prescaler runs while on, reset while off
// - Start begins at next converter clock edge
// - Conversion lasts 13, first lasts 25
// - Sample at 1.5, first at 13.5
// - Completion writes result, sets flag, clears start
// - Auto conversion samples at 2, lasts 13.5
// - Free running restarts immediately, start stays set
// - Code 1111 selects temperature sensor
// - Differential codes use gain, single-ended bypass
// - Selection buffer frozen during conversion
`include "sacs_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module sacs_sequencer (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    // Control bits from software
    input wire converter_on_bit,
    input wire auto_trigger_on,
    input wire [2:0] trigger_source_select,
    input wire left_align_select,
    input wire [3:0] channel_gain_select,
    input wire [2:0] reference_select,
    input wire [2:0] clock_divider_select,
    // Software strobes
    input wire start_write,
    input wire done_flag_clear,
    input wire read_low_strobe,
    input wire read_high_strobe,
    // Trigger sources, index 0 unused (done flag)
    input wire [7:0] trigger_sources,
    // Comparator result from analog core
    input wire comp_in,
    // Status to software
    output reg conversion_start_bit,
    output reg conversion_done_flag,
    output reg conversion_complete,
    output reg [7:0] result_low_byte,
    output reg [7:0] result_high_byte,
    // Analog control
    output reg analog_enable,
    output reg sample_hold,
    output reg [9:0] sar_dac_code,
    output reg [3:0] applied_channel,
    output reg [2:0] applied_reference,
    output reg temp_sensor_sel,
    output reg gain_bypass,
    output reg gain_20x
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Last prescaler count of a full converter period, ratio 2 to 256
    function [7:0] ratio_last;
        input [2:0] sel;
        reg [8:0] r;
        begin
            r = 9'h002 << sel;
            ratio_last = r[7:0] - 8'h01;
        end
    endfunction

    // Last prescaler count of the first half period
    function [7:0] half_last;
        input [2:0] sel;
        reg [8:0] r;
        begin
            r = 9'h001 << sel;
            half_last = r[7:0] - 8'h01;
        end
    endfunction

    // Single-ended codes bypass the gain stage
    function is_single;
        input [3:0] code;
        begin
            is_single = (code[3:2] == 2'h0) || (code == `SACS_CH_TEMP);
        end
    endfunction

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [1:0] ST_IDLE = 2'b01; // Waiting for a start
    localparam [1:0] ST_CONV = 2'b10; // Conversion running

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [1:0] state_ff; // One-hot state
    reg [7:0] presc_ff; // Prescaler count
    reg [5:0] hc_ff; // Half cycles since start
    reg [1:0] mode_ff; // Timing mode of this conversion
    reg first_ff; // Next conversion is the first one
    reg start_pend_ff; // Start written, waiting for clock edge
    reg sampled_ff; // Sample point passed
    reg [9:0] bit_ff; // Bit under trial, one-hot
    reg lock_ff; // Result registers blocked
    reg [2:0] trig_pipe_ff; // Trigger synchroniser and edge stage

    // ----------------------------------------
    // Combinational decode
    // ----------------------------------------
    wire busy = state_ff[1];
    // Prescaler taps, counted only while on
    wire tick_half = (presc_ff == half_last(clock_divider_select));
    wire tick_full = (presc_ff == ratio_last(clock_divider_select));
    wire trig_lvl = trigger_sources[trigger_source_select];
    // Two core cycles of synchronising logic before the edge
    wire trig_edge = trig_pipe_ff[1] & ~trig_pipe_ff[2];
    // Edge only counts when auto is on, idle, and source not the done flag
    wire auto_start = converter_on_bit & auto_trigger_on & ~busy &
                      (trigger_source_select != `SACS_TRIG_DONE_FLAG) &
                      trig_edge;
    // Written start waits for the converter clock edge
    wire soft_start = converter_on_bit & ~busy & start_pend_ff & tick_full;
    reg [5:0] hc_sample;
    reg [5:0] hc_end;
    always @* begin
        case (mode_ff)
            `SACS_MODE_FIRST: begin
                hc_sample = `SACS_HC_SAMPLE_FIRST;
                hc_end = `SACS_HC_END_FIRST;
            end
            `SACS_MODE_AUTO: begin
                hc_sample = `SACS_HC_SAMPLE_AUTO;
                hc_end = `SACS_HC_END_AUTO;
            end
            default: begin
                hc_sample = `SACS_HC_SAMPLE_NORM;
                hc_end = `SACS_HC_END_NORM;
            end
        endcase
    end
    wire hc_step = tick_half | tick_full;
    wire finish = busy & hc_step & (hc_ff == hc_end - 6'h01);
    // Free running: done flag as source restarts regardless of flag
    wire free_run = auto_trigger_on &
                    (trigger_source_select == `SACS_TRIG_DONE_FLAG);
    // Last converter cycle before completion reopens the buffer
    wire last_cycle = busy & (hc_ff >= hc_end - 6'h02);
    // SAR result with the final trial bit decided
    wire [9:0] sar_final = comp_in ? sar_dac_code : (sar_dac_code & ~bit_ff);

    // ----------------------------------------
    // Prescaler
    // ----------------------------------------
    // Held in reset while off; a trigger restarts it so delay is fixed
    always @(posedge core_clk) begin
        if (!rstn || !converter_on_bit || auto_start) begin
            presc_ff <= 8'h00;
        end else if (tick_full) begin
            presc_ff <= 8'h00;
        end else begin
            presc_ff <= presc_ff + 8'h01;
        end
    end

    // ----------------------------------------
    // Trigger synchroniser
    // ----------------------------------------
    // First stage read only by the second
    always @(posedge core_clk) begin
        if (!rstn) begin
            trig_pipe_ff <= 3'h0;
        end else begin
            trig_pipe_ff <= {trig_pipe_ff[1:0], trig_lvl};
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
            hc_ff <= 6'h00;
            mode_ff <= `SACS_MODE_NORM;
            first_ff <= 1'b1;
            start_pend_ff <= 1'b0;
            sampled_ff <= 1'b0;
            bit_ff <= 10'h000;
            sar_dac_code <= 10'h000;
            sample_hold <= 1'b0;
            conversion_start_bit <= 1'b0;
        end else begin
            sample_hold <= 1'b0;
            if (!converter_on_bit) begin
                // Switching off aborts; next switch-on runs a first conversion
                state_ff <= ST_IDLE;
                first_ff <= 1'b1;
                start_pend_ff <= 1'b0;
                sampled_ff <= 1'b0;
                conversion_start_bit <= start_write;
                if (start_write) begin
                    start_pend_ff <= 1'b1;
                end
            end else begin
                case (state_ff)
                    ST_IDLE: begin
                        if (start_write) begin
                            start_pend_ff <= 1'b1;
                            conversion_start_bit <= 1'b1;
                        end
                        if (soft_start || auto_start) begin
                            state_ff <= ST_CONV;
                            hc_ff <= 6'h00;
                            start_pend_ff <= 1'b0;
                            sampled_ff <= 1'b0;
                            first_ff <= 1'b0;
                            conversion_start_bit <= 1'b1;
                            if (first_ff) begin
                                mode_ff <= `SACS_MODE_FIRST;
                            end else if (soft_start) begin
                                mode_ff <= `SACS_MODE_NORM;
                            end else begin
                                mode_ff <= `SACS_MODE_AUTO;
                            end
                        end
                    end
                    ST_CONV: begin
                        // Start bit held high for the whole conversion
                        conversion_start_bit <= 1'b1;
                        if (hc_step) begin
                            hc_ff <= hc_ff + 6'h01;
                        end
                        // Sample-and-hold instant
                        if (hc_step && !sampled_ff && hc_ff == hc_sample - 6'h01) begin
                            sample_hold <= 1'b1;
                            sampled_ff <= 1'b1;
                            bit_ff <= `SACS_SAR_MSB;
                            sar_dac_code <= `SACS_SAR_MSB;
                        end else if (tick_full && sampled_ff && bit_ff != 10'h000) begin
                            // One bit decided per converter cycle
                            sar_dac_code <= sar_final | (bit_ff >> 1);
                            bit_ff <= bit_ff >> 1;
                        end
                        if (finish) begin
                            sampled_ff <= 1'b0;
                            hc_ff <= 6'h00;
                            if (free_run) begin
                                // Next conversion begins at once
                                state_ff <= ST_CONV;
                                mode_ff <= `SACS_MODE_NORM;
                            end else begin
                                state_ff <= ST_IDLE;
                                conversion_start_bit <= 1'b0;
                            end
                        end
                    end
                    default: begin
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Result, lock and completion flag
    // ----------------------------------------
    // Partial bits still untried read as zero at the end
    wire [9:0] result = sar_dac_code & ~bit_ff;
    always @(posedge core_clk) begin
        if (!rstn) begin
            result_low_byte <= 8'h00;
            result_high_byte <= 8'h00;
            lock_ff <= 1'b0;
            conversion_done_flag <= 1'b0;
            conversion_complete <= 1'b0;
        end else begin
            conversion_complete <= finish;
            // Low read blocks, high read releases
            if (read_high_strobe) begin
                lock_ff <= 1'b0;
            end else if (read_low_strobe) begin
                lock_ff <= 1'b1;
            end
            // Blocked result is dropped
            if (finish && !lock_ff) begin
                if (left_align_select) begin
                    result_high_byte <= result[9:2];
                    result_low_byte <= {result[1:0], 6'h00};
                end else begin
                    result_high_byte <= {6'h00, result[9:8]};
                    result_low_byte <= result[7:0];
                end
            end
            // Set wins over a clear in the same cycle
            if (finish) begin
                conversion_done_flag <= 1'b1;
            end else if (done_flag_clear) begin
                conversion_done_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Selection buffer and analog routing
    // ----------------------------------------
    // Tracks software only while on and not mid-conversion
    always @(posedge core_clk) begin
        if (!rstn) begin
            applied_channel <= 4'h0;
            applied_reference <= 3'h0;
            temp_sensor_sel <= 1'b0;
            gain_bypass <= 1'b1;
            gain_20x <= 1'b0;
            analog_enable <= 1'b0;
        end else begin
            analog_enable <= converter_on_bit;
            // Frozen during conversion, open again in its last cycle
            if (converter_on_bit && (!busy || last_cycle) &&
                !(soft_start || auto_start)) begin
                applied_channel <= channel_gain_select;
                applied_reference <= reference_select;
                temp_sensor_sel <= (channel_gain_select == `SACS_CH_TEMP);
                gain_bypass <= is_single(channel_gain_select);
                gain_20x <= ~is_single(channel_gain_select) &
                            channel_gain_select[0];
            end
        end
    end

endmodule // sacs_sequencer

`default_nettype wire

// >>> dv/sacs_seq_props.sv
// Purpose: Port-level assertions for the conversion sequencer
// Assumes: One core clock domain, synchronous active-low reset
// Notes: Bound into every sacs_sequencer instance at the foot
`timescale 1ns/1ps
`default_nettype none
module sacs_seq_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Control seen
    input wire logic [2:0] clock_divider_select,
    input wire logic done_flag_clear,
    input wire logic read_low_strobe,
    input wire logic read_high_strobe,
    // Status watched
    input wire logic conversion_start_bit,
    input wire logic conversion_done_flag,
    input wire logic conversion_complete,
    input wire logic [7:0] result_low_byte,
    input wire logic [7:0] result_high_byte,
    // Analog control watched
    input wire logic analog_enable,
    input wire logic sample_hold,
    input wire logic [3:0] applied_channel,
    input wire logic [2:0] applied_reference,
    input wire logic temp_sensor_sel,
    input wire logic gain_bypass,
    input wire logic gain_20x
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    // Lock mirror; a high byte read wins over a low byte read
    logic lock_ff;
    always @(posedge core_clk) begin
        lock_ff <= rstn & ~read_high_strobe & (read_low_strobe | lock_ff);
    end
    // Completion step
    sequence s_done;
        conversion_complete && conversion_done_flag;
    endsequence
    // Every kind of conversion ends 11.5 converter cycles after sampling
    sequence s_tail;
        ##23 conversion_complete;
    endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    start_clear_a: assert property ($fell(conversion_start_bit) |-> s_done)
        else $error("start bit cleared without completion");
    flag_rise_a: assert property ($rose(conversion_done_flag) |-> conversion_complete)
        else $error("done flag set without completion");
    lost_flag_a: assert property (conversion_complete |-> conversion_done_flag)
        else $error("completion without done flag");
    flag_sticky_a: assert property (conversion_done_flag && !done_flag_clear |=> conversion_done_flag)
        else $error("done flag dropped without clear");
    busy_sample_a: assert property (sample_hold |-> conversion_start_bit && analog_enable)
        else $error("sample outside a running conversion");
    sel_freeze_a: assert property (sample_hold |-> $stable(applied_channel) && $stable(applied_reference))
        else $error("selection moved during conversion");
    lock_hold_a: assert property (lock_ff |=> $stable(result_low_byte) && $stable(result_high_byte))
        else $error("result changed while locked");
    single_bypass_a: assert property (applied_channel[3:2] == 2'h0 |-> gain_bypass && !gain_20x)
        else $error("single-ended channel not bypassed");
    diff_gain_a: assert property (applied_channel[3:2] != 2'h0 && applied_channel != 4'hF
        |-> !gain_bypass && gain_20x == applied_channel[0])
        else $error("differential gain wrong");
    temp_sel_a: assert property (temp_sensor_sel == (applied_channel == 4'hF))
        else $error("temperature sensor select wrong");
    hold_done_a: assert property (sample_hold && clock_divider_select == 3'h0 |-> s_tail)
        else $error("sample to completion spacing wrong");
endmodule // sacs_seq_props
bind sacs_sequencer sacs_seq_props u_props (.core_clk(core_clk), .rstn(rstn),
    .clock_divider_select(clock_divider_select), .done_flag_clear(done_flag_clear),
    .read_low_strobe(read_low_strobe), .read_high_strobe(read_high_strobe),
    .conversion_start_bit(conversion_start_bit), .conversion_done_flag(conversion_done_flag),
    .conversion_complete(conversion_complete), .result_low_byte(result_low_byte),
    .result_high_byte(result_high_byte), .analog_enable(analog_enable),
    .sample_hold(sample_hold), .applied_channel(applied_channel),
    .applied_reference(applied_reference), .temp_sensor_sel(temp_sensor_sel),
    .gain_bypass(gain_bypass), .gain_20x(gain_20x));
`default_nettype wire

// >>> dv/sacs_analog_model.sv
// Purpose: Comparator model of the analog core behind the sequencer
// Assumes: Ideal comparator, one input level per applied channel
// Notes: Output churns while the converter is off
`timescale 1ns/1ps
`default_nettype none
module sacs_analog_model (
    // Clock
    input wire logic core_clk,
    // Analog control
    input wire logic analog_enable,
    input wire logic [9:0] sar_dac_code,
    input wire logic [3:0] applied_channel,
    // Level base from the bench
    input wire logic [9:0] base_level,
    // Comparator result
    output logic comp_in
);
    // Churn so an unpowered comparator never looks valid
    logic churn_ff = 1'h0;
    always @(posedge core_clk) churn_ff <= ~churn_ff;
    // Channel folded into the level, so a late channel switch shows up
    always_comb begin
        comp_in = analog_enable ? ({base_level[9:4], base_level[3:0] ^ applied_channel}
            >= sar_dac_code) : churn_ff;
    end
endmodule // sacs_analog_model
`default_nettype wire

// >>> dv/sar_adc_conversion_sequencer_tb_top.sv
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Divider select 0 gives one core clock per half converter cycle
// Notes: Software accesses are one-cycle strobes driven on rising edges
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_sequencer_tb_top;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic core_clk = 1'h0, rstn = 1'h0, converter_on_bit = 1'h0, auto_trigger_on = 1'h0;
    logic left_align_select = 1'h0, start_write = 1'h0, done_flag_clear = 1'h0;
    logic read_low_strobe = 1'h0, read_high_strobe = 1'h0, start_q = 1'h0;
    logic [2:0] trigger_source_select = 3'h0, reference_select = 3'h0, clock_divider_select = 3'h0;
    logic [3:0] channel_gain_select = 4'h0;
    logic [7:0] trigger_sources = 8'h00;
    logic [9:0] base_level = 10'h2A5;
    wire comp_in, conversion_start_bit, conversion_done_flag, conversion_complete;
    wire analog_enable, sample_hold, temp_sensor_sel, gain_bypass, gain_20x;
    wire [7:0] result_low_byte, result_high_byte;
    wire [9:0] sar_dac_code;
    wire [3:0] applied_channel;
    wire [2:0] applied_reference;
    int err_count = 0, samples_checked = 0, cyc_count = 0, n_done = 0, n_fall = 0, c, i, n0;
    // 125 MHz core clock
    always #4 core_clk = ~core_clk;
    sacs_sequencer dut (.core_clk(core_clk), .rstn(rstn), .converter_on_bit(converter_on_bit),
        .auto_trigger_on(auto_trigger_on), .trigger_source_select(trigger_source_select),
        .left_align_select(left_align_select), .channel_gain_select(channel_gain_select),
        .reference_select(reference_select), .clock_divider_select(clock_divider_select),
        .start_write(start_write), .done_flag_clear(done_flag_clear),
        .read_low_strobe(read_low_strobe), .read_high_strobe(read_high_strobe),
        .trigger_sources(trigger_sources), .comp_in(comp_in),
        .conversion_start_bit(conversion_start_bit), .conversion_done_flag(conversion_done_flag),
        .conversion_complete(conversion_complete), .result_low_byte(result_low_byte),
        .result_high_byte(result_high_byte), .analog_enable(analog_enable),
        .sample_hold(sample_hold), .sar_dac_code(sar_dac_code),
        .applied_channel(applied_channel), .applied_reference(applied_reference),
        .temp_sensor_sel(temp_sensor_sel), .gain_bypass(gain_bypass), .gain_20x(gain_20x));
    sacs_analog_model u_analog (.core_clk(core_clk), .analog_enable(analog_enable),
        .sar_dac_code(sar_dac_code), .applied_channel(applied_channel),
        .base_level(base_level), .comp_in(comp_in));
    // Completion and start-bit fall counters, plus the hang guard
    always @(posedge core_clk) begin
        start_q <= conversion_start_bit;
        n_done <= n_done + (rstn && conversion_complete);
        n_fall <= n_fall + (start_q && !conversion_start_bit);
        cyc_count <= cyc_count + 1;
        if (cyc_count == 20000) begin
            err_count++;
            stop_test;
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Software strobe: 0 start, 1 low read, 2 high read, 3 flag clear
    task pulse(input int k);
        @(posedge core_clk);
        case (k)
            0: start_write <= 1'h1;
            1: read_low_strobe <= 1'h1;
            2: read_high_strobe <= 1'h1;
            default: done_flag_clear <= 1'h1;
        endcase
        @(posedge core_clk);
        {start_write, read_low_strobe, read_high_strobe, done_flag_clear} <= 4'h0;
    endtask
    // Bounded wait for the completion pulse, sampled mid-cycle
    task wait_done(output int n);
        n = 0;
        @(negedge core_clk);
        while (conversion_complete !== 1'h1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 400) begin
            err_count++;
            $display("ERROR %0t: no completion", $time);
        end
        // Back on a rising edge, so following stimulus is edge-aligned
        @(posedge core_clk);
    endtask
    task conv(output int n);
        pulse(0);
        @(negedge core_clk);
        chk(conversion_start_bit, 1'h1);
        wait_done(n);
    endtask
    // Expected byte pair for a level and alignment
    function automatic logic [15:0] pair(input logic [3:0] ch, input logic left);
        logic [9:0] r;
        r = {base_level[9:4], base_level[3:0] ^ ch};
        pair = left ? {r, 6'h00} : {6'h00, r};
    endfunction
    task stop_test;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        tick(5);
        rstn <= 1'h1;
        channel_gain_select <= 4'h5;
        reference_select <= 3'h4;
        tick(4);
        chk(applied_channel, 4'h0);
        chk(applied_reference, 3'h0);
        converter_on_bit <= 1'h1;
        tick(4);
        chk(applied_channel, 4'h5);
        chk(applied_reference, 3'h4);
        chk(analog_enable, 1'h1);
        // Every channel code while idle
        for (i = 0; i < 16; i++) begin
            channel_gain_select <= i[3:0];
            tick(3);
            chk(temp_sensor_sel, i == 15);
            if (i < 15) chk({gain_bypass, gain_20x}, i < 4 ? 2'h2 : {1'h0, i[0]});
        end
        channel_gain_select <= 4'h2;
        tick(3);
        conv(c);
        chk(c >= 50 && c <= 56, 1'h1);
        chk(conversion_start_bit, 1'h0);
        chk({result_high_byte, result_low_byte}, pair(4'h2, 1'h0));
        left_align_select <= 1'h1;
        conv(c);
        chk(c >= 26 && c <= 32, 1'h1);
        chk({result_high_byte, result_low_byte}, pair(4'h2, 1'h1));
        // Channel switch in mid-conversion
        pulse(0);
        tick(8);
        channel_gain_select <= 4'h1;
        tick(2);
        chk(applied_channel, 4'h2);
        wait_done(c);
        chk({result_high_byte, result_low_byte}, pair(4'h2, 1'h1));
        tick(3);
        chk(applied_channel, 4'h1);
        // Low byte read locks the pair; the lost result still flags
        pulse(3);
        @(negedge core_clk);
        chk(conversion_done_flag, 1'h0);
        pulse(1);
        base_level <= 10'h13C;
        conv(c);
        chk(conversion_done_flag, 1'h1);
        chk({result_high_byte, result_low_byte}, {10'h2A7, 6'h00});
        pulse(2);
        conv(c);
        chk({result_high_byte, result_low_byte}, pair(4'h1, 1'h1));
        // Divide by 4 doubles the conversion
        clock_divider_select <= 3'h1;
        conv(c);
        chk(c >= 52 && c <= 62, 1'h1);
        clock_divider_select <= 3'h0;
        auto_trigger_on <= 1'h1;
        trigger_source_select <= 3'h3;
        conv(c);
        // Trigger edge, ignored second edge, held level
        @(posedge core_clk);
        n0 = n_done;
        trigger_sources <= 8'h08;
        tick(10);
        chk(conversion_start_bit, 1'h1);
        trigger_sources <= 8'h00;
        tick(2);
        trigger_sources <= 8'h08;
        wait_done(c);
        chk(c + 12 >= 29 && c + 12 <= 35, 1'h1);
        tick(80);
        chk(n_done, n0 + 1);
        trigger_sources <= 8'h00;
        tick(2);
        trigger_sources <= 8'h08;
        wait_done(c);
        tick(1);
        chk(n_done, n0 + 2);
        trigger_sources <= 8'h00;
        // Done flag as trigger, never cleared
        trigger_source_select <= 3'h0;
        tick(40);
        n0 = n_done;
        i = n_fall;
        pulse(0);
        tick(120);
        chk(n_done >= n0 + 3, 1'h1);
        chk(n_fall, i);
        auto_trigger_on <= 1'h0;
        wait_done(c);
        tick(40);
        converter_on_bit <= 1'h0;
        tick(4);
        chk(analog_enable, 1'h0);
        stop_test;
    end
endmodule // sar_adc_conversion_sequencer_tb_top
`default_nettype wire
